// [common/udc_consts.vh]
// Constants for the up/down threshold counter bank
`ifndef UDC_CONSTS_VH
`define UDC_CONSTS_VH
`define UDC_NUM_CNT 32
`define UDC_CNT_W 32
`define UDC_IDX_W 5
`define UDC_ADDR_W 8
// Register offsets; each counter owns a block of eight words
`define UDC_OFS_CTRL 3'h0
`define UDC_OFS_UPPER 3'h1
`define UDC_OFS_LOWER 3'h2
`define UDC_OFS_PRESET 3'h3
`define UDC_OFS_COUNT 3'h4
`define UDC_OFS_FLAGS 3'h5
// Global registers use spare word slots of the last two counters,
// so all thirty-two counter blocks stay reachable in the 8-bit map
`define UDC_ADDR_IRQ_STAT 8'hf6
`define UDC_ADDR_IRQ_MASK 8'hf7
`define UDC_ADDR_RELEASE 8'hfe
`define UDC_ADDR_ENABLE 8'hff
// Control bit positions
`define UDC_CTRL_PULSE 0
`define UDC_CTRL_DIR 1
`define UDC_CTRL_LOAD 2
`define UDC_CTRL_CLEAR 3
// Flag bit positions
`define UDC_FLG_UPPER 0
`define UDC_FLG_LOWER 1
`define UDC_FLG_ZERO 2
`define UDC_FLG_CARRY 3
`define UDC_ZERO_W 32'h0000_0000
// Signed count range ends and the count step
`define UDC_CNT_MAX 32'h7fff_ffff
`define UDC_CNT_MIN 32'h8000_0000
`define UDC_ONE_W 32'h0000_0001
`endif

// [logic/udc_cell.v]
// One up/down counter with thresholds and flags
`timescale 1ns/1ns
`default_nettype none
`include "udc_consts.vh"
module udc_cell (
  input wire ref_clk,
  input wire srst,
  input wire active,
  input wire pulse_in,
  input wire dir_in,
  input wire load_in,
  input wire clear_in,
  input wire [31:0] upper_limit,
  input wire [31:0] lower_limit,
  input wire [31:0] preset_value,
  output reg [31:0] actual_count,
  output reg upper_reached_flag,
  output reg lower_reached_flag,
  output reg zero_flag,
  output reg carry_flag
);
  reg pulse_q;
  reg load_q;
  reg [31:0] cnt_d;
  reg carry_d;
  wire pulse_rise;
  wire load_rise;
  // Edge memory runs always, so an enable does not fake an edge
  always @(posedge ref_clk) begin
    if (srst) begin
      pulse_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      pulse_q <= pulse_in;
      load_q <= load_in;
    end
  end
  assign pulse_rise = pulse_in & ~pulse_q;
  assign load_rise = load_in & ~load_q;
  // Next count: clear beats load beats counting
  always @* begin
    cnt_d = actual_count;
    carry_d = 1'b0;
    if (active) begin
      if (clear_in) begin
        cnt_d = `UDC_ZERO_W;
      end else if (load_rise) begin
        cnt_d = preset_value;
      end else if (pulse_rise) begin
        // Count one step; out of range keeps last value, pulses carry
        if (!dir_in) begin
          if (actual_count == `UDC_CNT_MAX) begin
            carry_d = 1'b1;
          end else begin
            cnt_d = actual_count + `UDC_ONE_W;
          end
        end else begin
          if (actual_count == `UDC_CNT_MIN) begin
            carry_d = 1'b1;
          end else begin
            cnt_d = actual_count - `UDC_ONE_W;
          end
        end
      end
    end
  end
  always @(posedge ref_clk) begin
    if (srst) begin
      actual_count <= `UDC_ZERO_W;
      carry_flag <= 1'b0;
      upper_reached_flag <= 1'b0;
      lower_reached_flag <= 1'b0;
      zero_flag <= 1'b0;
    end else begin
      actual_count <= cnt_d;
      carry_flag <= carry_d;
      upper_reached_flag <= $signed(cnt_d) >= $signed(upper_limit);
      lower_reached_flag <= $signed(cnt_d) <= $signed(lower_limit);
      zero_flag <= (cnt_d == `UDC_ZERO_W);
    end
  end
endmodule
`default_nettype wire

// [logic/udc_irq.v]
// Sticky interrupt status with mask
`timescale 1ns/1ns
`default_nettype none
`include "udc_consts.vh"
module udc_irq (
  input wire ref_clk,
  input wire srst,
  input wire [31:0] events,
  input wire clr_we,
  input wire [31:0] clr_data,
  input wire mask_we,
  input wire [31:0] mask_data,
  output reg [31:0] status_q,
  output reg [31:0] mask_q,
  output reg irq
);
  // A new event wins over a write-one clear in the same cycle
  always @(posedge ref_clk) begin
    if (srst) begin
      status_q <= `UDC_ZERO_W;
      mask_q <= `UDC_ZERO_W;
      irq <= 1'b0;
    end else begin
      status_q <= (status_q & ~(clr_we ? clr_data : `UDC_ZERO_W)) | events;
      if (mask_we) begin
        mask_q <= mask_data;
      end
      irq <= |(status_q & mask_q);
    end
  end
endmodule
`default_nettype wire

// [logic/udc_bank.v]
// Bank of 32 up/down threshold counters with register port
//
// Contract
// - Thirty-two independent up/down counters, each with a 32-bit signed count.
// - Each counter compares its count with upper and lower thresholds.
// - Each counter takes a preset value that can become the count.
// - Inputs are sampled and the count updated once per scan.
// - With release required, counter acts only while enabled; otherwise always.
// - Count by one on pulse rising edge; direction 0 up, 1 down.
// - Rising edge on load replaces count with preset value.
// - While clear is high the count is held at zero.
// - Upper flag when count >= upper; lower flag when count <= lower.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "udc_consts.vh"
module udc_bank (
  input wire ref_clk,
  input wire srst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  output reg irq
);
  //////////////////////////////////////////////////////////////////////
  // Register storage; one ref_clk cycle stands for one program scan
  reg [3:0] ctrl_q [0:`UDC_NUM_CNT-1];
  reg [31:0] upper_q [0:`UDC_NUM_CNT-1];
  reg [31:0] lower_q [0:`UDC_NUM_CNT-1];
  reg [31:0] preset_q [0:`UDC_NUM_CNT-1];
  reg [31:0] release_q;
  reg [31:0] enable_q;
  wire [31:0] cnt_w [0:`UDC_NUM_CNT-1];
  wire [3:0] flg_w [0:`UDC_NUM_CNT-1];
  wire [31:0] carry_ev;
  wire [31:0] stat_w;
  wire [31:0] mask_w;
  wire irq_w;
  wire [4:0] idx;
  wire [2:0] ofs;
  wire cnt_space;
  integer i;
  assign idx = addr[7:3];
  assign ofs = addr[2:0];
  // Counter words are offsets up to the flags word; spare slots hold globals
  assign cnt_space = (ofs <= `UDC_OFS_FLAGS);

  //////////////////////////////////////////////////////////////////////
  // Register writes; single writer per counter is the driver's duty
  // One write per cycle
  always @(posedge ref_clk) begin
    if (srst) begin
      for (i = 0; i < `UDC_NUM_CNT; i = i + 1) begin
        ctrl_q[i] <= 4'h0;
        upper_q[i] <= `UDC_ZERO_W;
        lower_q[i] <= `UDC_ZERO_W;
        preset_q[i] <= `UDC_ZERO_W;
      end
      release_q <= `UDC_ZERO_W;
      enable_q <= `UDC_ZERO_W;
    end else if (wr_stb) begin
      if (cnt_space) begin
        case (ofs)
          `UDC_OFS_CTRL: ctrl_q[idx] <= wdata[3:0];
          `UDC_OFS_UPPER: upper_q[idx] <= wdata;
          `UDC_OFS_LOWER: lower_q[idx] <= wdata;
          `UDC_OFS_PRESET: preset_q[idx] <= wdata;
          default: ;
        endcase
      end else if (addr == `UDC_ADDR_RELEASE) begin
        release_q <= wdata;
      end else if (addr == `UDC_ADDR_ENABLE) begin
        enable_q <= wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Counter instances
  // Thirty-two counters
  genvar g;
  generate
    for (g = 0; g < `UDC_NUM_CNT; g = g + 1) begin : g_cnt
      wire act = ~release_q[g] | enable_q[g];
      udc_cell u_cell (
        .ref_clk(ref_clk),
        .srst(srst),
        .active(act),
        .pulse_in(ctrl_q[g][`UDC_CTRL_PULSE]),
        .dir_in(ctrl_q[g][`UDC_CTRL_DIR]),
        .load_in(ctrl_q[g][`UDC_CTRL_LOAD]),
        .clear_in(ctrl_q[g][`UDC_CTRL_CLEAR]),
        .upper_limit(upper_q[g]),
        .lower_limit(lower_q[g]),
        .preset_value(preset_q[g]),
        .actual_count(cnt_w[g]),
        .upper_reached_flag(flg_w[g][`UDC_FLG_UPPER]),
        .lower_reached_flag(flg_w[g][`UDC_FLG_LOWER]),
        .zero_flag(flg_w[g][`UDC_FLG_ZERO]),
        .carry_flag(flg_w[g][`UDC_FLG_CARRY])
      );
      assign carry_ev[g] = flg_w[g][`UDC_FLG_CARRY];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Interrupts: carry pulses are caught sticky so software never misses one
  udc_irq u_irq (
    .ref_clk(ref_clk),
    .srst(srst),
    .events(carry_ev),
    .clr_we(wr_stb & (addr == `UDC_ADDR_IRQ_STAT)),
    .clr_data(wdata),
    .mask_we(wr_stb & (addr == `UDC_ADDR_IRQ_MASK)),
    .mask_data(wdata),
    .status_q(stat_w),
    .mask_q(mask_w),
    .irq(irq_w)
  );
  // Output from a flip-flop; adds one cycle of delay
  always @(posedge ref_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_w;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read data; unmapped addresses read zero
  always @(posedge ref_clk) begin
    if (srst) begin
      rdata <= `UDC_ZERO_W;
    end else if (rd_stb) begin
      if (cnt_space) begin
        case (ofs)
          `UDC_OFS_CTRL: rdata <= {28'h0000000, ctrl_q[idx]};
          `UDC_OFS_UPPER: rdata <= upper_q[idx];
          `UDC_OFS_LOWER: rdata <= lower_q[idx];
          `UDC_OFS_PRESET: rdata <= preset_q[idx];
          `UDC_OFS_COUNT: rdata <= cnt_w[idx];
          `UDC_OFS_FLAGS: rdata <= {28'h0000000, flg_w[idx]};
          default: rdata <= `UDC_ZERO_W;
        endcase
      end else begin
        case (addr)
          `UDC_ADDR_IRQ_STAT: rdata <= stat_w;
          `UDC_ADDR_IRQ_MASK: rdata <= mask_w;
          `UDC_ADDR_RELEASE: rdata <= release_q;
          `UDC_ADDR_ENABLE: rdata <= enable_q;
          default: rdata <= `UDC_ZERO_W;
        endcase
      end
    end else begin
      rdata <= `UDC_ZERO_W;
    end
  end
endmodule
`default_nettype wire

// [sim/udc_bank_monitor.sv]
// Port-level checker for the counter bank
`timescale 1ns/1ns
`default_nettype none
module udc_bank_monitor (
  input wire ref_clk,
  input wire srst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] rdata,
  input wire irq
);
  reg [31:0] sh_q [0:255];
  reg [7:0] ra_q;
  reg rd_q;
  integer i;
  wire [31:0] msk = sh_q[247];
  wire cfg = (ra_q[2:0] != 3'h0 && ra_q[2:0] < 3'h4) || ra_q == 8'hf7 || ra_q >= 8'hfe;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // Shadow of written words; the status word is shadowed too but never checked
  always @(posedge ref_clk) begin
    if (srst) begin
      for (i = 0; i < 256; i = i + 1) sh_q[i] <= 32'h0;
      rd_q <= 1'b0;
    end else begin
      if (wr_stb) sh_q[addr] <= wdata;
      rd_q <= rd_stb;
    end
    ra_q <= addr;
  end
  a_rdata_idle: assert property (!rd_q |-> rdata == 32'h0)
    else $error("read data outside read slot");
  a_reset_quiet: assert property ($fell(srst) |-> rdata == 32'h0 && !irq)
    else $error("outputs not quiet after reset");
  a_cfg_readback: assert property (rd_q && cfg |-> rdata == sh_q[ra_q])
    else $error("config word readback differs");
  a_ctrl_readback: assert property (rd_q && ra_q[2:0] == 3'h0
    |-> rdata == {28'h0, sh_q[ra_q][3:0]})
    else $error("control readback differs");
  a_flag_width: assert property (rd_q && ra_q[2:0] == 3'h5 |-> rdata[31:4] == 28'h0)
    else $error("flag word upper bits set");
  a_gap_zero: assert property (rd_q && ra_q[2:0] > 3'h5 && ra_q[7:4] != 4'hf
    |-> rdata == 32'h0)
    else $error("unmapped word not zero");
  a_irq_mask: assert property (irq |-> msk != 0 || $past(msk) != 0
    || $past(msk, 2) != 0)
    else $error("interrupt with mask empty");
  a_irq_drops: assert property ((wr_stb && addr == 8'hf7 && wdata == 32'h0)
    ##1 !(wr_stb && addr == 8'hf7) |-> ##2 !irq)
    else $error("interrupt stays after unmask");
  c_count_read: cover property (rd_q && ra_q[2:0] == 3'h4);
  c_irq_high: cover property (irq);
  c_irq_fall: cover property ($fell(irq));
endmodule
`default_nettype wire

// [sim/udc_prog.sv]
// Program-side model driving the counter bank's register port
`timescale 1ns/1ns
`default_nettype none
module udc_prog (
  input wire ref_clk,
  output var logic [7:0] addr,
  output var logic [31:0] wdata,
  output var logic wr_stb,
  output var logic rd_stb,
  input wire [31:0] rdata
);
  initial begin
    addr = 8'h0;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic pulse(input logic [7:0] a, input logic dn);
    wr(a, {30'h0, dn, 1'b1});
    @(posedge ref_clk);
    wr(a, {30'h0, dn, 1'b0});
    @(posedge ref_clk);
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    q = rdata;
  endtask
endmodule
`default_nettype wire

// [sim/udc_bank_tb.sv]
// Self-checking bench for the counter bank
`timescale 1ns/1ns
`default_nettype none
module udc_bank_tb;
  logic ref_clk;
  logic srst;
  wire [7:0] addr;
  wire [31:0] wdata;
  wire wr_stb;
  wire rd_stb;
  wire [31:0] rdata;
  wire irq;
  int errors;
  int n_tests;
  udc_bank i_udc_bank (.ref_clk(ref_clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq));
  udc_prog i_udc_prog (.ref_clk(ref_clk), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
  ////////////////////////////////////////
  // 125 MHz scan clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic give_verdict;
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    i_udc_prog.wr(a, d);
  endtask
  task automatic p(input logic [7:0] a, input logic dn);
    i_udc_prog.pulse(a, dn);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_udc_prog.rd(a, q);
    n_tests++;
    if (q !== e) begin
      errors++;
      $display("unexpected rdata %h: exp %h got %h", a, e, q);
    end
  endtask
  // Interrupt lags its cause by three registers
  task automatic ic(input logic e);
    repeat (3) @(posedge ref_clk);
    #1;
    n_tests++;
    if (irq !== e) begin
      errors++;
      $display("unexpected irq: exp %b got %b", e, irq);
    end
  endtask
  // Generous bound; the sequence needs about 150 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    give_verdict;
  end
  initial begin
    srst = 1'b1;
    errors = 0;
    n_tests = 0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    w(8'h09, 32'h3);
    w(8'h0a, 32'h1);
    repeat (3) p(8'h08, 1'b0);
    rc(8'h09, 32'h3);
    rc(8'h0c, 32'h3);
    rc(8'h0d, 32'h1);
    p(8'h08, 1'b1);
    rc(8'h0c, 32'h2);
    rc(8'h0d, 32'h0);
    w(8'h0b, 32'd100);
    w(8'h08, 32'h4);
    rc(8'h0c, 32'd100);
    w(8'h08, 32'h8);
    rc(8'h0c, 32'h0);
    rc(8'h0d, 32'h6);
    w(8'h08, 32'hc);
    rc(8'h0c, 32'h0);
    w(8'h08, 32'h0);
    rc(8'h0c, 32'h0);
    rc(8'h0e, 32'h0);
    w(8'h13, 32'h7fff_ffff);
    w(8'h10, 32'h4);
    p(8'h10, 1'b0);
    rc(8'h14, 32'h7fff_ffff);
    rc(8'hf6, 32'h4);
    ic(1'b0);
    w(8'hf7, 32'h4);
    ic(1'b1);
    w(8'hf7, 32'h0);
    ic(1'b0);
    w(8'hf7, 32'h4);
    ic(1'b1);
    w(8'hf6, 32'h4);
    ic(1'b0);
    rc(8'hf6, 32'h0);
    w(8'h1b, 32'h8000_0000);
    w(8'h18, 32'h6);
    p(8'h18, 1'b1);
    rc(8'h1c, 32'h8000_0000);
    rc(8'h1d, 32'h2);
    rc(8'hf6, 32'h8);
    w(8'hfe, 32'h8000_0000);
    p(8'hf8, 1'b0);
    rc(8'hfc, 32'h0);
    w(8'hff, 32'h8000_0000);
    p(8'hf8, 1'b0);
    rc(8'hfc, 32'h1);
    rc(8'h0c, 32'h0);
    give_verdict;
  end
endmodule
bind udc_bank udc_bank_monitor i_udc_bank_monitor (.ref_clk(ref_clk), .srst(srst),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq));
`default_nettype wire
